// ==== hw/fpec_top.sv ====
// Flash program/erase control: APB registers, mode gating and interrupt.
// Assumes a 32-bit APB master on clock; chip reset, mode and permit pins pass through fpec_mode_latch.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
//
// Operation
// - Erase bit sets only with pin permit, software permit and erase setup high.
// - Program bit sets only with pin permit, software permit and program setup high.
// - Second control register: read-only, fault flag bit 7, cleared by resets, standby.
// - Second control register reads zero while the on-chip flash is disabled.
// - Operating mode is latched from mode and permit pins at reset release.
// - User mode allows reads but blocks every program and erase.
// - Program and erase allowed only in boot, user program and programmer modes.
// - Normal mode with on-chip ROM offers neither boot nor user program mode.
// - In user program mode the permit pin may toggle anytime; device accepts it.
module fpec_top
   import fpec_pkg::*;
#(
   parameter int ADDR_W = FPEC_ADDR_W
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic chipRstN,
   input wire logic [2:0] modeSelectPins,
   input wire logic writePermitPin,
   input wire logic hwStandby,
   input wire logic swStandby,
   input wire logic flashEnabled,
   input wire logic flashFaultEvent,
   output logic wipeActive,
   output logic burnActive,
   output logic writeAllowed,
   output fpec_mode_e opMode,
   output logic irq
);
   import fpec_pkg::*;

   // Elaboration check: offsets must fit the address bus
   if (ADDR_W < FPEC_ADDR_W)
      $error("fpec_top: ADDR_W too narrow for the register map");

   logic chipResetHeld;
   logic writePermitSync;
   fpec_mode_e latchedMode;

   fpec_mode_latch u_latch
   (
      .clock(clock),
      .rst(rst),
      .clkEn(clkEn),
      .chipRstN(chipRstN),
      .modeSelectPins(modeSelectPins),
      .writePermitPin(writePermitPin),
      .chipResetHeld(chipResetHeld),
      .writePermitSync(writePermitSync),
      .opMode(latchedMode)
   );

   logic [6:0] ctrl1_reg, ctrl1_next;
   logic fault_reg, fault_next;
   logic [FPEC_IRQ_W-1:0] irqStat_reg, irqStat_next;
   logic [FPEC_IRQ_W-1:0] irqMask_reg, irqMask_next;
   logic irq_reg, irq_next;
   logic standbyA_reg, standbyB_reg;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [31:0] prdata_reg, prdata_next;
   logic allowed_reg, allowed_next;
   logic modeOk;
   logic wrStrobe;
   logic [FPEC_IRQ_W-1:0] events;
   logic refused;
   logic aborted;
   logic [6:0] wrBits;

   // Register select decode, shared by read and write paths
   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      return a == ADDR_W'(FPEC_OFS_CTRL1) || a == ADDR_W'(FPEC_OFS_CTRL2)
         || a == ADDR_W'(FPEC_OFS_MODE) || a == ADDR_W'(FPEC_OFS_IRQ_STATUS)
         || a == ADDR_W'(FPEC_OFS_IRQ_MASK);
   endfunction

   function automatic logic isReadOnly(input logic [ADDR_W-1:0] a);
      return a == ADDR_W'(FPEC_OFS_CTRL2) || a == ADDR_W'(FPEC_OFS_MODE);
   endfunction

   // Modes that may program or erase; user mode only reads
   always_comb
   begin
      modeOk = 1'b0;
      unique case (latchedMode)
         FPEC_MODE_USER: modeOk = 1'b0;
         FPEC_MODE_BOOT: modeOk = 1'b1;
         FPEC_MODE_USER_PROG: modeOk = 1'b1;
         FPEC_MODE_PROM: modeOk = 1'b1;
      endcase
   end

   // Hardware standby pin crosses into the clock domain
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         standbyA_reg <= 1'b0;
         standbyB_reg <= 1'b0;
      end
      else if (clkEn)
      begin
         standbyA_reg <= hwStandby;
         standbyB_reg <= standbyA_reg;
      end
   end

   // Write strobe: access phase with our zero-wait ready
   assign wrStrobe = psel && penable && pready_reg && pwrite
      && paddr == ADDR_W'(FPEC_OFS_CTRL1);

   // First control register and mode-bit gating
   always_comb
   begin
      ctrl1_next = ctrl1_reg;
      refused = 1'b0;
      aborted = 1'b0;
      wrBits = pwdata[6:0];
      allowed_next = writePermitSync && modeOk && flashEnabled;
      if (wrStrobe)
      begin
         ctrl1_next = wrBits;
         // Set conditions use the stored setup bits, so a combined write cannot set
         if (wrBits[FPEC_BIT_WIPE] && !(allowed_reg && writePermitSync
            && ctrl1_reg[FPEC_BIT_SW_PERMIT] && ctrl1_reg[FPEC_BIT_WIPE_SETUP]))
         begin
            ctrl1_next[FPEC_BIT_WIPE] = ctrl1_reg[FPEC_BIT_WIPE] && writePermitSync;
            refused = !ctrl1_reg[FPEC_BIT_WIPE];
         end
         if (wrBits[FPEC_BIT_BURN] && !(allowed_reg && writePermitSync
            && ctrl1_reg[FPEC_BIT_SW_PERMIT] && ctrl1_reg[FPEC_BIT_BURN_SETUP]))
         begin
            ctrl1_next[FPEC_BIT_BURN] = ctrl1_reg[FPEC_BIT_BURN] && writePermitSync;
            refused = refused || !ctrl1_reg[FPEC_BIT_BURN];
         end
      end
      // Pin loss drops any active mode bit at once
      if (!writePermitSync)
      begin
         aborted = ctrl1_reg[FPEC_BIT_WIPE] || ctrl1_reg[FPEC_BIT_BURN];
         ctrl1_next[FPEC_BIT_WIPE] = 1'b0;
         ctrl1_next[FPEC_BIT_BURN] = 1'b0;
      end
      if (chipResetHeld || standbyB_reg)
         ctrl1_next = FPEC_CTRL1_RESET[6:0];
   end

   // Error flag: set by the array, cleared by every reset and standby
   always_comb
   begin
      fault_next = fault_reg || flashFaultEvent;
      if (chipResetHeld || standbyB_reg || swStandby)
         fault_next = FPEC_CTRL2_RESET[FPEC_BIT_FAULT];
   end

   // Sticky interrupt status; a new event wins over a write-one clear
   always_comb
   begin
      events = '0;
      events[FPEC_IRQ_FAULT] = flashFaultEvent && !fault_reg;
      events[FPEC_IRQ_REFUSED] = refused;
      events[FPEC_IRQ_ABORT] = aborted;
      irqStat_next = irqStat_reg;
      irqMask_next = irqMask_reg;
      if (psel && penable && pready_reg && pwrite)
      begin
         if (paddr == ADDR_W'(FPEC_OFS_IRQ_STATUS))
            irqStat_next = irqStat_reg & ~pwdata[FPEC_IRQ_W-1:0];
         if (paddr == ADDR_W'(FPEC_OFS_IRQ_MASK))
            irqMask_next = pwdata[FPEC_IRQ_W-1:0];
      end
      irqStat_next = irqStat_next | events;
      irq_next = |(irqStat_next & irqMask_next);
   end

   // APB answer: ready in the first access cycle, data captured at setup
   always_comb
   begin
      pready_next = psel && !penable;
      pslverr_next = 1'b0;
      prdata_next = prdata_reg;
      if (psel && !penable)
      begin
         prdata_next = '0;
         pslverr_next = !isMapped(paddr) || (pwrite && isReadOnly(paddr));
         if (!pwrite)
         begin
            unique case (1'b1)
               paddr == ADDR_W'(FPEC_OFS_CTRL1):
                  prdata_next[7:0] = {writePermitSync, ctrl1_reg};
               paddr == ADDR_W'(FPEC_OFS_CTRL2):
                  prdata_next[FPEC_BIT_FAULT] = fault_reg && flashEnabled;
               paddr == ADDR_W'(FPEC_OFS_MODE):
                  prdata_next[1:0] = latchedMode;
               paddr == ADDR_W'(FPEC_OFS_IRQ_STATUS):
                  prdata_next[FPEC_IRQ_W-1:0] = irqStat_reg;
               paddr == ADDR_W'(FPEC_OFS_IRQ_MASK):
                  prdata_next[FPEC_IRQ_W-1:0] = irqMask_reg;
               default:
                  prdata_next = '0;
            endcase
         end
      end
   end

   // Block registers apart from the standby synchroniser; frozen while the clock enable is low
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         ctrl1_reg <= FPEC_CTRL1_RESET[6:0];
         fault_reg <= FPEC_CTRL2_RESET[FPEC_BIT_FAULT];
         irqStat_reg <= FPEC_IRQ_RESET;
         irqMask_reg <= FPEC_IRQ_RESET;
         irq_reg <= 1'b0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0;
         allowed_reg <= 1'b0;
      end
      else if (clkEn)
      begin
         ctrl1_reg <= ctrl1_next;
         fault_reg <= fault_next;
         irqStat_reg <= irqStat_next;
         irqMask_reg <= irqMask_next;
         irq_reg <= irq_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
         allowed_reg <= allowed_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign wipeActive = ctrl1_reg[FPEC_BIT_WIPE];
   assign burnActive = ctrl1_reg[FPEC_BIT_BURN];
   assign writeAllowed = allowed_reg;
   assign opMode = latchedMode;
   assign irq = irq_reg;
endmodule

// ==== hw/fpec_pkg.sv ====
// Constants and types shared by the flash program/erase control block.
// Assumes a 32-bit APB with word-aligned registers and a 100 MHz clock.
package fpec_pkg;
   // Register byte offsets
   localparam logic [7:0] FPEC_OFS_CTRL1 = 8'h00;
   localparam logic [7:0] FPEC_OFS_CTRL2 = 8'h04;
   localparam logic [7:0] FPEC_OFS_MODE = 8'h08;
   localparam logic [7:0] FPEC_OFS_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] FPEC_OFS_IRQ_MASK = 8'h10;
   localparam int FPEC_ADDR_W = 8;
   // flash_control_one field positions
   localparam int FPEC_BIT_BURN = 0;
   localparam int FPEC_BIT_WIPE = 1;
   localparam int FPEC_BIT_BURN_CHECK = 2;
   localparam int FPEC_BIT_WIPE_CHECK = 3;
   localparam int FPEC_BIT_BURN_SETUP = 4;
   localparam int FPEC_BIT_WIPE_SETUP = 5;
   localparam int FPEC_BIT_SW_PERMIT = 6;
   localparam int FPEC_BIT_PIN_PERMIT = 7;
   // flash_control_two field position
   localparam int FPEC_BIT_FAULT = 7;
   // Interrupt status / mask positions
   localparam int FPEC_IRQ_FAULT = 0;
   localparam int FPEC_IRQ_REFUSED = 1;
   localparam int FPEC_IRQ_ABORT = 2;
   localparam int FPEC_IRQ_W = 3;
   // Reset values
   localparam logic [7:0] FPEC_CTRL1_RESET = 8'h00;
   localparam logic [7:0] FPEC_CTRL2_RESET = 8'h00;
   localparam logic [FPEC_IRQ_W-1:0] FPEC_IRQ_RESET = 3'h0;
   // Mode pin codes
   localparam logic [2:0] FPEC_PINS_PROM = 3'h0;
   localparam logic [2:0] FPEC_PINS_BOOT = 3'h5;
   localparam logic [2:0] FPEC_PINS_NORMAL_ROM = 3'h6;
   localparam logic [2:0] FPEC_PINS_USER_PROG = 3'h7;
   // Least reset pin low time, in system clock cycles
   localparam int FPEC_RESET_MIN_CYCLES = 20;
   localparam int FPEC_RESET_CNT_W = 5;

   typedef enum logic [1:0] {FPEC_MODE_USER, FPEC_MODE_BOOT, FPEC_MODE_USER_PROG,
      FPEC_MODE_PROM} fpec_mode_e;
endpackage

// ==== hw/fpec_mode_latch.sv ====
// Pin synchronisers, reset-pin qualification and operating mode latch.
// Assumes chip reset, mode and write-permit pins are asynchronous to clock.
`timescale 1ns/10ps
module fpec_mode_latch
   import fpec_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic chipRstN,
   input wire logic [2:0] modeSelectPins,
   input wire logic writePermitPin,
   output logic chipResetHeld,
   output logic writePermitSync,
   output fpec_mode_e opMode
);
   logic [4:0] syncA_reg, syncA_next;
   logic [4:0] syncB_reg, syncB_next;
   logic [FPEC_RESET_CNT_W-1:0] lowCnt_reg, lowCnt_next;
   logic held_reg, held_next;
   fpec_mode_e mode_reg, mode_next;
   logic pinLow;
   logic [2:0] pinsNow;

   // Mode decode from pins sampled during reset
   function automatic fpec_mode_e decodeMode(input logic [2:0] pins, input logic permit);
      fpec_mode_e m;
      m = FPEC_MODE_USER;
      if (pins == FPEC_PINS_PROM)
         m = FPEC_MODE_PROM;
      else if (permit && pins == FPEC_PINS_BOOT)
         m = FPEC_MODE_BOOT;
      else if (permit && pins == FPEC_PINS_USER_PROG)
         m = FPEC_MODE_USER_PROG;
      // Normal ROM pins, and boot or user program pins without permit, stay in user mode
      return m;
   endfunction

   // Next state: two-stage sync, then count low time and latch mode
   always_comb
   begin
      syncA_next = {chipRstN, modeSelectPins, writePermitPin};
      syncB_next = syncA_reg;
      pinLow = ~syncB_reg[4];
      pinsNow = syncB_reg[3:1];
      lowCnt_next = lowCnt_reg;
      held_next = held_reg;
      mode_next = mode_reg;
      if (!pinLow)
      begin
         lowCnt_next = '0;
         held_next = 1'b0;
      end
      else if (lowCnt_reg != FPEC_RESET_CNT_W'(FPEC_RESET_MIN_CYCLES - 1))
         lowCnt_next = lowCnt_reg + 1'b1;
      else
         held_next = 1'b1; // Glitches shorter than the minimum are ignored
      // Mode follows the pins while reset holds, frozen at release
      if (pinLow && (held_reg || held_next))
         mode_next = decodeMode(pinsNow, syncB_reg[0]);
   end

   // Registers; frozen while the clock enable is low
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         syncA_reg <= 5'h10;
         syncB_reg <= 5'h10;
         lowCnt_reg <= '0;
         held_reg <= 1'b0;
         mode_reg <= FPEC_MODE_USER;
      end
      else if (clkEn)
      begin
         syncA_reg <= syncA_next;
         syncB_reg <= syncB_next;
         lowCnt_reg <= lowCnt_next;
         held_reg <= held_next;
         mode_reg <= mode_next;
      end
   end

   assign chipResetHeld = held_reg;
   assign writePermitSync = syncB_reg[0]; // Live pin level, changes accepted anytime
   assign opMode = mode_reg;
endmodule

// ==== tb/fpec_host_model.sv ====
// Behavioural host on the chip pins: reset pulse, mode pins, permit pin.
// Assumes the bench calls its tasks; single clock domain.
`timescale 1ns/10ps
module fpec_host_model
(
   input wire logic clock,
   output logic chipRstN,
   output logic [2:0] modeSelectPins,
   output logic writePermitPin
);
   // Permit low until operation is stable
   initial
   begin
      chipRstN = 1'b1;
      modeSelectPins = 3'h6;
      writePermitPin = 1'b0;
   end
   // Pins move only inside the reset pulse, held past the minimum
   task automatic chip_reset(input logic [2:0] pins, input logic permit);
      @(posedge clock);
      chipRstN <= 1'b0;
      @(posedge clock);
      modeSelectPins <= pins;
      writePermitPin <= permit;
      repeat (24) @(posedge clock);
      chipRstN <= 1'b1;
      repeat (4) @(posedge clock);
   endtask
   // Free permit change, legal in user program mode only
   task automatic set_permit(input logic permit);
      @(posedge clock);
      writePermitPin <= permit;
   endtask
endmodule

// ==== tb/fpec_top_sva.sv ====
// Checker for fpec_top: mode-bit gating, read-only status, flash-off reads.
// Assumes clkEn stays high; bound to every fpec_top.
`timescale 1ns/10ps
module fpec_top_sva
   import fpec_pkg::*;
#(
   parameter int ADDR_W = FPEC_ADDR_W
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic chipRstN,
   input wire logic writePermitPin,
   input wire logic flashEnabled,
   input wire logic wipeActive,
   input wire logic burnActive,
   input wire logic writeAllowed,
   input wire fpec_pkg::fpec_mode_e opMode,
   input wire logic irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Mode bits rise only on an allowed write that carries them
   property p_wipe;
      $rose(wipeActive) |-> $past(psel && penable && pwrite && paddr == FPEC_OFS_CTRL1
         && pwdata[FPEC_BIT_WIPE] && writeAllowed);
   endproperty
   a_wipe: assert property (p_wipe) else $error("erase bit set without cause");
   property p_burn;
      $rose(burnActive) |-> $past(psel && penable && pwrite && paddr == FPEC_OFS_CTRL1
         && pwdata[FPEC_BIT_BURN] && writeAllowed);
   endproperty
   a_burn: assert property (p_burn) else $error("program bit set without cause");
   // Two sync flops plus the clear, with a cycle to spare
   property p_pin_loss;
      !writePermitPin [*5] |-> !wipeActive && !burnActive;
   endproperty
   a_pin_loss: assert property (p_pin_loss) else $error("mode bit kept without pin");
   property p_user;
      opMode == FPEC_MODE_USER && $past(opMode) == FPEC_MODE_USER |-> !writeAllowed;
   endproperty
   a_user: assert property (p_user) else $error("writes allowed in user mode");
   property p_modes;
      writeAllowed |-> $past(opMode) != FPEC_MODE_USER && $past(flashEnabled);
   endproperty
   a_modes: assert property (p_modes) else $error("writes allowed in wrong mode");
   property p_ro;
      psel && !penable && pwrite && paddr == FPEC_OFS_CTRL2 |=> pready && pslverr;
   endproperty
   a_ro: assert property (p_ro) else $error("status write not refused");
   property p_off;
      psel && !penable && !pwrite && paddr == FPEC_OFS_CTRL2 && !flashEnabled
         |=> pready && prdata == 32'h0;
   endproperty
   a_off: assert property (p_off) else $error("status nonzero, flash off");
   property p_toggle;
      (opMode == FPEC_MODE_USER_PROG && writePermitPin && flashEnabled && chipRstN) [*6]
         |-> writeAllowed;
   endproperty
   a_toggle: assert property (p_toggle) else $error("permit pin not followed");
   c_wipe: cover property ($rose(wipeActive));
   c_burn: cover property ($rose(burnActive));
   c_irq: cover property ($rose(irq));
endmodule
bind fpec_top fpec_top_sva #(.ADDR_W(ADDR_W)) chk_u (.clock(clock), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .chipRstN(chipRstN), .writePermitPin(writePermitPin),
   .flashEnabled(flashEnabled), .wipeActive(wipeActive), .burnActive(burnActive),
   .writeAllowed(writeAllowed), .opMode(opMode), .irq(irq));

// ==== tb/testbench.sv ====
// Bench for fpec_top: registers, mode gating, fault flag, interrupt.
// Assumes fpec_host_model drives the chip pins; clkEn tied high.
`timescale 1ns/10ps
module testbench;
   import fpec_pkg::*;
   logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, fault = 0;
   logic hwStandby = 0, swStandby = 0, flashEnabled = 1, pready, pslverr, err;
   logic chipRstN, writePermitPin, wipeActive, burnActive, writeAllowed, irq;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [2:0] modeSelectPins;
   fpec_mode_e opMode;
   int num_errors = 0, comparisons = 0, cycles = 0;
   always #5 clock = ~clock;
   fpec_host_model host_u (.clock(clock), .chipRstN(chipRstN),
      .modeSelectPins(modeSelectPins), .writePermitPin(writePermitPin));
   fpec_top dut_u (.clock(clock), .rst(rst), .clkEn(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chipRstN(chipRstN), .modeSelectPins(modeSelectPins),
      .writePermitPin(writePermitPin), .hwStandby(hwStandby), .swStandby(swStandby),
      .flashEnabled(flashEnabled), .flashFaultEvent(fault), .wipeActive(wipeActive),
      .burnActive(burnActive), .writeAllowed(writeAllowed), .opMode(opMode), .irq(irq));
   task automatic end_of_test();
      $display("checks %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Hang guard, well above the run length
   always @(posedge clock)
   begin
      cycles++;
      if (cycles > 5000)
      begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // APB transfer; data and error taken at the pready edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check("pready", {31'h0, pready}, 32'h1);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check("read", rd, exp);
   endtask
   task automatic settle(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   // Mode decode across pin codes, with and without permit
   task automatic t_modes();
      logic [2:0] pins [5] = '{FPEC_PINS_PROM, FPEC_PINS_BOOT, FPEC_PINS_USER_PROG,
         FPEC_PINS_NORMAL_ROM, FPEC_PINS_BOOT};
      logic [1:0] exp [5] = '{2'h3, 2'h1, 2'h2, 2'h0, 2'h0};
      for (int i = 0; i < 5; i++)
      begin
         host_u.chip_reset(pins[i], i < 4);
         rdchk(FPEC_OFS_MODE, {30'h0, exp[i]});
         check("opMode", {30'h0, opMode}, {30'h0, exp[i]});
      end
   endtask
   // Gating, refused combined set, pin loss and its interrupt
   task automatic t_prog();
      host_u.chip_reset(FPEC_PINS_USER_PROG, 1'b1);
      apb(1'b1, FPEC_OFS_IRQ_STATUS, 32'h7);
      apb(1'b1, FPEC_OFS_IRQ_MASK, 32'h4);
      apb(1'b1, FPEC_OFS_CTRL1, 32'h40);
      apb(1'b1, FPEC_OFS_CTRL1, 32'h73);
      settle(1);
      check("modes", {wipeActive, burnActive}, 32'h0);
      apb(1'b1, FPEC_OFS_CTRL1, 32'h51);
      rdchk(FPEC_OFS_CTRL1, 32'hd1);
      apb(1'b1, FPEC_OFS_CTRL1, 32'h60);
      apb(1'b1, FPEC_OFS_CTRL1, 32'h62);
      settle(1); // only registers are touched while a mode bit is set
      check("wipe", wipeActive, 32'h1);
      host_u.set_permit(1'b0);
      settle(6);
      check("pin loss", {wipeActive, irq}, 32'h1);
      apb(1'b1, FPEC_OFS_IRQ_STATUS, 32'h4);
      apb(1'b1, FPEC_OFS_CTRL1, 32'h62);
      settle(1);
      check("no pin", {wipeActive, irq}, 32'h0);
      host_u.set_permit(1'b1);
      settle(5);
      check("allowed", writeAllowed, 32'h1);
   endtask
   // User mode refuses mode bits
   task automatic t_user();
      host_u.chip_reset(FPEC_PINS_NORMAL_ROM, 1'b1);
      apb(1'b1, FPEC_OFS_IRQ_STATUS, 32'h7);
      apb(1'b1, FPEC_OFS_CTRL1, 32'h60);
      apb(1'b1, FPEC_OFS_CTRL1, 32'h62);
      settle(1);
      check("user", {wipeActive, writeAllowed}, 32'h0);
      rdchk(FPEC_OFS_IRQ_STATUS, 32'h2);
   endtask
   // Fault flag: read-only, hidden when flash off, cleared by standby
   task automatic t_fault();
      @(posedge clock) fault <= 1'b1;
      @(posedge clock) fault <= 1'b0;
      apb(1'b1, FPEC_OFS_CTRL2, 32'h0);
      check("ro", err, 32'h1);
      rdchk(FPEC_OFS_CTRL2, 32'h80);
      @(posedge clock) flashEnabled <= 1'b0;
      rdchk(FPEC_OFS_CTRL2, 32'h0);
      @(posedge clock) flashEnabled <= 1'b1;
      @(posedge clock) swStandby <= 1'b1;
      @(posedge clock) swStandby <= 1'b0;
      rdchk(FPEC_OFS_CTRL2, 32'h0);
      @(posedge clock) fault <= 1'b1;
      @(posedge clock) fault <= 1'b0;
      rdchk(FPEC_OFS_CTRL2, 32'h80);
      hwStandby <= 1'b1;
      repeat (4) @(posedge clock);
      hwStandby <= 1'b0;
      rdchk(FPEC_OFS_CTRL2, 32'h0);
   endtask
   initial
   begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rdchk(FPEC_OFS_CTRL1, 32'h0);
      rdchk(FPEC_OFS_CTRL2, 32'h0);
      apb(1'b1, 8'h14, 32'hff);
      check("unmapped err", {31'h0, err}, 32'h1);
      check("unmapped rd", rd, 32'h0);
      t_modes();
      t_user();
      t_prog();
      t_fault();
      end_of_test();
   end
endmodule
